/* hw/tick_timer_pkg.sv */
// Constants shared by the system tick timer and its helper modules.
// Assumes one 100 MHz core clock and a classic Wishbone register port.
// How it works
// - Soft interrupt trigger bit holds its request until software writes it 0.
// - With auto-reload on, up-count restarts at zero the tick after match; down-count reloads the match value at zero.
// - Without reload, up-count runs past match; down-count wraps zero to ones.
// - Clock select 1 ticks every core cycle, 0 ticks every eighth cycle.
// - Tick interrupt enable gates whether a match raises the tick interrupt.
// - Run enable 1 counts; 0 halts the counter holding its value.
// - Match flag sets when the up-counting value reaches the match value.
// - Writing 0 clears the match flag; writing 1 leaves it unchanged.
// - The 32-bit counter value is readable and writable at any time.
// - The 32-bit match value register is readable, writable and compared.
// - Control, status and counter decode at F000, F004, F008; reset zero.
// - Match value decodes at F010, offset 0x0c is unused; resets zero.
package tick_timer_pkg;

  // Register byte addresses.
  localparam logic [31:0] ADDR_CTRL = 32'he000f000;
  localparam logic [31:0] ADDR_STAT = 32'he000f004;
  localparam logic [31:0] ADDR_CNT = 32'he000f008;
  localparam logic [31:0] ADDR_MATCH = 32'he000f010;
  localparam logic [31:0] ADDR_MODE = 32'he000f014;
  localparam logic [31:0] ADDR_EVT_STAT = 32'he000f020;
  localparam logic [31:0] ADDR_EVT_CLR = 32'he000f024;
  localparam logic [31:0] ADDR_EVT_EN = 32'he000f028;

  // Control, status and mode field positions.
  localparam int CTRL_RUN = 0;
  localparam int CTRL_IRQ_EN = 1;
  localparam int CTRL_CLK_SEL = 2;
  localparam int CTRL_RELOAD = 3;
  localparam int CTRL_SOFT = 31;
  localparam int STAT_MATCH = 0;
  localparam int MODE_DOWN = 0;

  // Event bits of the interrupt event bank.
  localparam int EVT_MATCH = 0;
  localparam int EVT_RESTART = 1;
  localparam int EVT_NUM = 2;

  // Value after reset, the all-ones wrap value and the slow tick divider.
  localparam logic [31:0] RESET_WORD = 32'h0000_0000;
  localparam logic [31:0] ALL_ONES = 32'hffff_ffff;
  localparam int unsigned TICK_DIV = 8;

endpackage

/* hw/tick_divider.sv */
// Tick enable generator for the system tick timer.
// Assumes a synchronous active-low reset already released in clock domain.
`timescale 1ns/10ps
module tick_divider #(
  parameter int unsigned DIV = 8
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic run,
  input wire logic direct,
  output logic tick
);
  localparam int CW = (DIV > 1) ? $clog2(DIV) : 1;
  localparam logic [CW-1:0] LAST = CW'(DIV - 1);

  logic [CW-1:0] div_r;
  logic div_wrap;

  // The prescaler restarts whenever the counter is stopped, so the first
  // slow tick after a start comes a full period later.
  assign div_wrap = div_r == LAST;
  assign tick = run & (direct | div_wrap);

  // Prescaler count.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      div_r <= '0;
    end else if (!run || div_wrap) begin
      div_r <= '0;
    end else begin
      div_r <= div_r + CW'(1);
    end
  end
endmodule

/* hw/event_irq_bank.sv */
// Sticky event status with enable mask and write-one-to-clear.
// Assumes one-cycle event and clear pulses from the owning block.
`timescale 1ns/10ps
module event_irq_bank #(
  parameter int unsigned N = 2
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [N-1:0] evt_set,
  input wire logic [N-1:0] evt_clr,
  input wire logic en_we,
  input wire logic [N-1:0] en_d,
  output logic [N-1:0] status,
  output logic [N-1:0] enable,
  output logic irq
);
  logic [N-1:0] status_r;
  logic [N-1:0] enable_r;

  assign status = status_r;
  assign enable = enable_r;
  assign irq = |(status_r & enable_r);

  // An event in the same cycle as its clear keeps the bit set.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      status_r <= '0;
      enable_r <= '0;
    end else begin
      status_r <= (status_r & ~evt_clr) | evt_set;
      if (en_we) begin
        enable_r <= en_d;
      end
    end
  end
endmodule

/* hw/system_tick_timer.sv */
// System tick timer: 32-bit counter, match flag and interrupt requests.
// Assumes a classic Wishbone master on the core clock; RST_N is async.
//
// Decided for this implementation: the Wishbone slave port.
`timescale 1ns/10ps
module system_tick_timer
  import tick_timer_pkg::*;
#(
  parameter int unsigned DIV = TICK_DIV
) (
  input wire logic CORE_CLK,
  input wire logic RST_N,
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_WE_I,
  input wire logic [31:0] WB_ADR_I,
  input wire logic [3:0] WB_SEL_I,
  input wire logic [31:0] WB_DAT_I,
  output logic [31:0] WB_DAT_O,
  output logic WB_ACK_O,
  output logic TICK_IRQ,
  output logic SOFT_IRQ,
  output logic EVT_IRQ
);
  logic rst_meta_r;
  logic rst_n_r;
  logic ack_r;
  logic [31:0] dat_r;
  logic soft_irq_trigger_r;
  logic auto_reload_enable_r;
  logic tick_clock_select_r;
  logic tick_irq_enable_r;
  logic counter_run_enable_r;
  logic count_down_r;
  logic match_flag_r;
  logic [31:0] tick_value_r;
  logic [31:0] match_value_r;

  // Reset is released through two flops; only the second is used.
  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      rst_meta_r <= 1'b0;
      rst_n_r <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_n_r <= rst_meta_r;
    end
  end

  // Bus decode. A write lands on the edge where the master sees ack.
  wire req = WB_CYC_I & WB_STB_I;
  wire req_new = req & ~ack_r;
  wire wr_fire = req & WB_WE_I & ack_r;
  wire hit_ctrl = WB_ADR_I == ADDR_CTRL;
  wire hit_stat = WB_ADR_I == ADDR_STAT;
  wire hit_cnt = WB_ADR_I == ADDR_CNT;
  wire hit_match = WB_ADR_I == ADDR_MATCH;
  wire hit_mode = WB_ADR_I == ADDR_MODE;
  wire hit_evs = WB_ADR_I == ADDR_EVT_STAT;
  wire hit_evc = WB_ADR_I == ADDR_EVT_CLR;
  wire hit_eve = WB_ADR_I == ADDR_EVT_EN;
  wire wr_ctrl = wr_fire & hit_ctrl;
  wire wr_stat = wr_fire & hit_stat;
  wire wr_cnt = wr_fire & hit_cnt;
  wire wr_match = wr_fire & hit_match;
  wire wr_mode = wr_fire & hit_mode;
  wire wr_evc = wr_fire & hit_evc;
  wire wr_eve = wr_fire & hit_eve;

  // Byte lanes of the write data.
  wire [31:0] wmask = {{8{WB_SEL_I[3]}}, {8{WB_SEL_I[2]}},
                       {8{WB_SEL_I[1]}}, {8{WB_SEL_I[0]}}};

  // Read views of the registers; unused bits read as zero.
  wire [31:0] ctrl_rd = {soft_irq_trigger_r, 27'h0000000,
                         auto_reload_enable_r, tick_clock_select_r,
                         tick_irq_enable_r, counter_run_enable_r};
  wire [31:0] stat_rd = {31'h00000000, match_flag_r};
  wire [31:0] mode_rd = {31'h00000000, count_down_r};
  wire [EVT_NUM-1:0] evt_status;
  wire [EVT_NUM-1:0] evt_enable;
  wire [31:0] evs_rd = {{(32 - EVT_NUM){1'b0}}, evt_status};
  wire [31:0] eve_rd = {{(32 - EVT_NUM){1'b0}}, evt_enable};

  // Byte-merged write values for the plain read-write registers.
  wire [31:0] ctrl_w = (ctrl_rd & ~wmask) | (WB_DAT_I & wmask);
  wire [31:0] cnt_w = (tick_value_r & ~wmask) | (WB_DAT_I & wmask);
  wire [31:0] match_w = (match_value_r & ~wmask) | (WB_DAT_I & wmask);
  wire [31:0] eve_w = (eve_rd & ~wmask) | (WB_DAT_I & wmask);

  // Read mux; the clear register is write-only and reads zero, as do
  // unmapped addresses, which are still acknowledged.
  wire [31:0] rd_mux =
    hit_ctrl ? ctrl_rd :
    hit_stat ? stat_rd :
    hit_cnt ? tick_value_r :
    hit_match ? match_value_r :
    hit_mode ? mode_rd :
    hit_evs ? evs_rd :
    hit_eve ? eve_rd : RESET_WORD;

  // Ack one cycle after the request, dropped the cycle after. Read
  // data is captured at the request edge and held with ack.
  always_ff @(posedge CORE_CLK or negedge rst_n_r) begin
    if (!rst_n_r) begin
      ack_r <= 1'b0;
      dat_r <= RESET_WORD;
    end else begin
      ack_r <= req_new;
      if (req_new && !WB_WE_I) begin
        dat_r <= rd_mux;
      end
    end
  end

  assign WB_ACK_O = ack_r;
  assign WB_DAT_O = dat_r;

  // Tick source: every cycle or every DIV cycles while running.
  logic tick_en;

  tick_divider #(
    .DIV(DIV)
  ) u_div (
    .clk(CORE_CLK),
    .rst_n(rst_n_r),
    .run(counter_run_enable_r),
    .direct(tick_clock_select_r),
    .tick(tick_en)
  );

  // Next counter value for each direction.
  wire at_match = tick_value_r == match_value_r;
  wire at_zero = tick_value_r == RESET_WORD;
  wire at_ones = tick_value_r == ALL_ONES;
  wire [31:0] cnt_inc = tick_value_r + 32'h0000_0001;
  wire [31:0] cnt_dec = tick_value_r - 32'h0000_0001;
  wire reload_up = auto_reload_enable_r & at_match;
  wire [31:0] up_nxt = reload_up ? RESET_WORD : cnt_inc;
  // Down count with reload restarts from the match value at zero;
  // without it zero wraps to all ones.
  wire reload_dn = auto_reload_enable_r & at_zero;
  wire [31:0] dn_nxt = reload_dn ? match_value_r :
                       at_zero ? ALL_ONES : cnt_dec;
  wire [31:0] tick_value_nxt = count_down_r ? dn_nxt : up_nxt;

  // Events: the up count reaching match, and any restart or wrap. A
  // counter write in the same cycle wins over the tick and raises none.
  wire tick_live = tick_en & ~wr_cnt;
  wire match_hit = tick_live & ~count_down_r &
                   (up_nxt == match_value_r);
  wire restart_hit = tick_live &
                     (count_down_r ? at_zero : (reload_up | at_ones));

  // Control and mode registers.
  always_ff @(posedge CORE_CLK or negedge rst_n_r) begin
    if (!rst_n_r) begin
      soft_irq_trigger_r <= 1'b0;
      auto_reload_enable_r <= 1'b0;
      tick_clock_select_r <= 1'b0;
      tick_irq_enable_r <= 1'b0;
      counter_run_enable_r <= 1'b0;
      count_down_r <= 1'b0;
    end else begin
      if (wr_ctrl) begin
        soft_irq_trigger_r <= ctrl_w[CTRL_SOFT];
        auto_reload_enable_r <= ctrl_w[CTRL_RELOAD];
        tick_clock_select_r <= ctrl_w[CTRL_CLK_SEL];
        tick_irq_enable_r <= ctrl_w[CTRL_IRQ_EN];
        counter_run_enable_r <= ctrl_w[CTRL_RUN];
      end
      if (wr_mode && WB_SEL_I[0]) begin
        count_down_r <= WB_DAT_I[MODE_DOWN];
      end
    end
  end

  // Counter and match value. A software write beats a tick in the
  // same cycle, so the written value is exactly what is read back.
  always_ff @(posedge CORE_CLK or negedge rst_n_r) begin
    if (!rst_n_r) begin
      tick_value_r <= RESET_WORD;
      match_value_r <= RESET_WORD;
    end else begin
      if (wr_cnt) begin
        tick_value_r <= cnt_w;
      end else if (tick_en) begin
        tick_value_r <= tick_value_nxt;
      end
      if (wr_match) begin
        match_value_r <= match_w;
      end
    end
  end

  // Match flag: a 0 written to bit 0 clears it, a 1 does nothing, and a
  // match in the same cycle as the clear keeps it set.
  wire flag_clr = wr_stat & WB_SEL_I[0] & ~WB_DAT_I[STAT_MATCH];
  always_ff @(posedge CORE_CLK or negedge rst_n_r) begin
    if (!rst_n_r) begin
      match_flag_r <= 1'b0;
    end else if (match_hit) begin
      match_flag_r <= 1'b1;
    end else if (flag_clr) begin
      match_flag_r <= 1'b0;
    end
  end

  // Sticky event bank behind its own status, clear and enable words.
  wire [EVT_NUM-1:0] evt_set;
  assign evt_set[EVT_MATCH] = match_hit;
  assign evt_set[EVT_RESTART] = restart_hit;
  wire [EVT_NUM-1:0] evt_clr = {EVT_NUM{wr_evc & WB_SEL_I[0]}} &
                               WB_DAT_I[EVT_NUM-1:0];

  event_irq_bank #(
    .N(EVT_NUM)
  ) u_evt (
    .clk(CORE_CLK),
    .rst_n(rst_n_r),
    .evt_set(evt_set),
    .evt_clr(evt_clr),
    .en_we(wr_eve),
    .en_d(eve_w[EVT_NUM-1:0]),
    .status(evt_status),
    .enable(evt_enable),
    .irq(EVT_IRQ)
  );

  // Interrupt requests. The tick request is a level that follows the
  // flag, so software must clear the flag or the tick interrupt enable to end it.
  assign TICK_IRQ = tick_irq_enable_r & match_flag_r;
  assign SOFT_IRQ = soft_irq_trigger_r;

  // Checks that tie each output except EVT_IRQ back to its cause.
  property p_soft_hold;
    @(posedge CORE_CLK) disable iff (!rst_n_r)
    SOFT_IRQ && !wr_ctrl |=> SOFT_IRQ;
  endproperty
  a_soft_hold: assert property (p_soft_hold)
    else $error("Soft interrupt dropped without a control write.");

  property p_reload;
    @(posedge CORE_CLK) disable iff (!rst_n_r)
    tick_en && auto_reload_enable_r && !count_down_r && at_match &&
      !wr_cnt |=> tick_value_r == RESET_WORD;
  endproperty
  a_reload: assert property (p_reload)
    else $error("Counter did not restart at zero after match.");

  property p_run_past;
    @(posedge CORE_CLK) disable iff (!rst_n_r)
    tick_en && !auto_reload_enable_r && !count_down_r && !wr_cnt |=>
      tick_value_r == $past(tick_value_r) + 32'h0000_0001;
  endproperty
  a_run_past: assert property (p_run_past)
    else $error("Up count did not step by one.");

  property p_down_wrap;
    @(posedge CORE_CLK) disable iff (!rst_n_r)
    tick_en && count_down_r && !auto_reload_enable_r && at_zero &&
      !wr_cnt |=> tick_value_r == ALL_ONES;
  endproperty
  a_down_wrap: assert property (p_down_wrap)
    else $error("Down count did not wrap to all ones.");

  property p_slow_tick;
    @(posedge CORE_CLK) disable iff (!rst_n_r)
    tick_en && !tick_clock_select_r |=>
      (!tick_en || tick_clock_select_r) [*7];
  endproperty
  a_slow_tick: assert property (p_slow_tick)
    else $error("Slow tick came sooner than eight cycles.");

  property p_fast_tick;
    @(posedge CORE_CLK) disable iff (!rst_n_r)
    counter_run_enable_r && tick_clock_select_r && !wr_cnt && !reload_up &&
      !reload_dn |=> tick_value_r != $past(tick_value_r);
  endproperty
  a_fast_tick: assert property (p_fast_tick)
    else $error("Counter did not move on a direct tick.");

  property p_irq_gate;
    @(posedge CORE_CLK) disable iff (!rst_n_r)
    match_hit ##1 !$fell(tick_irq_enable_r) |->
      TICK_IRQ == tick_irq_enable_r;
  endproperty
  a_irq_gate: assert property (p_irq_gate)
    else $error("Tick interrupt not gated by its enable.");

  property p_halt;
    @(posedge CORE_CLK) disable iff (!rst_n_r)
    !counter_run_enable_r && !wr_cnt |=> $stable(tick_value_r);
  endproperty
  a_halt: assert property (p_halt)
    else $error("Counter moved while halted.");

  property p_flag_set;
    @(posedge CORE_CLK) disable iff (!rst_n_r)
    match_hit |=> match_flag_r ##1 (match_flag_r || $past(flag_clr));
  endproperty
  a_flag_set: assert property (p_flag_set)
    else $error("Match flag not set on match.");

  property p_flag_w1;
    @(posedge CORE_CLK) disable iff (!rst_n_r)
    wr_stat && WB_DAT_I[STAT_MATCH] && match_flag_r |=> match_flag_r;
  endproperty
  a_flag_w1: assert property (p_flag_w1)
    else $error("Writing one changed the match flag.");

  property p_cnt_write;
    @(posedge CORE_CLK) disable iff (!rst_n_r)
    wr_cnt && WB_SEL_I == 4'hf |=> tick_value_r == $past(WB_DAT_I);
  endproperty
  a_cnt_write: assert property (p_cnt_write)
    else $error("Counter write not taken.");

  property p_match_read;
    @(posedge CORE_CLK) disable iff (!rst_n_r)
    req_new && !WB_WE_I && hit_match |=>
      WB_ACK_O && WB_DAT_O == $past(match_value_r);
  endproperty
  a_match_read: assert property (p_match_read)
    else $error("Match value read back wrong.");

  property p_soft_set;
    @(posedge CORE_CLK) disable iff (!rst_n_r)
    wr_ctrl && WB_SEL_I[3] && WB_DAT_I[CTRL_SOFT] |=> SOFT_IRQ;
  endproperty
  a_soft_set: assert property (p_soft_set)
    else $error("Soft interrupt not raised by its control bit.");

  property p_down_step;
    @(posedge CORE_CLK) disable iff (!rst_n_r)
    tick_en && count_down_r && !at_zero && !wr_cnt |=>
      tick_value_r == $past(tick_value_r) - 32'h0000_0001;
  endproperty
  a_down_step: assert property (p_down_step)
    else $error("Down count did not step by one.");

  property p_flag_clear;
    @(posedge CORE_CLK) disable iff (!rst_n_r)
    flag_clr && !match_hit |=> !match_flag_r;
  endproperty
  a_flag_clear: assert property (p_flag_clear)
    else $error("Writing zero did not clear the match flag.");

  property p_unused_read;
    @(posedge CORE_CLK) disable iff (!rst_n_r)
    req_new && !WB_WE_I && WB_ADR_I == ADDR_MATCH - 32'h0000_0004 |=>
      WB_DAT_O == RESET_WORD;
  endproperty
  a_unused_read: assert property (p_unused_read)
    else $error("Unused offset did not read zero.");

endmodule

/* tb/wb_core_model.sv */
// Processor core model: a classic Wishbone master for the tick timer.
// Assumes one clock and a slave that always answers with ack.
`timescale 1ns/10ps
module wb_core_model (
  input wire logic clk,
  input wire logic ack,
  output logic cyc,
  output logic stb,
  output logic we,
  output logic [3:0] sel,
  output logic [31:0] adr,
  output logic [31:0] wdat
);
  // The bus is idle from time zero.
  initial begin
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
    sel = 4'h0;
    adr = 32'h0000_0000;
    wdat = 32'h0000_0000;
  end

  // One single cycle; the request is held until ack is sampled high.
  task automatic xfer(input logic w, input logic [31:0] a,
                      input logic [31:0] d, input logic [3:0] s);
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    sel <= s;
    adr <= a;
    wdat <= d;
    do @(posedge clk); while (ack !== 1'b1);
    cyc <= 1'b0;
    stb <= 1'b0;
    // Released data is inverted so no stale value can pass for a fresh one.
    wdat <= ~d;
  endtask
endmodule

/* tb/tb_top.sv */
// Self-checking bench for the system tick timer.
// Assumes the design files and the package are compiled before it.
`timescale 1ns/10ps
module tb_top;
  import tick_timer_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic cyc, stb, we, ack, tick_irq, soft_irq, evt_irq;
  logic [3:0] sel;
  logic [31:0] adr, wdat, rdat;
  logic [31:0] lfsr = 32'h0001_55e1;
  logic [31:0] exp_q[$];
  string name_q[$];
  int bad_count = 0;
  int num_checks = 0;
  int cyc_n = 0;

  // Free-running clock and an edge counter used to size run windows.
  always #5 clk = ~clk;
  always @(posedge clk) cyc_n <= cyc_n + 1;

  system_tick_timer dut_u (
    .CORE_CLK(clk), .RST_N(rst_n), .WB_CYC_I(cyc), .WB_STB_I(stb),
    .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(wdat),
    .WB_DAT_O(rdat), .WB_ACK_O(ack), .TICK_IRQ(tick_irq),
    .SOFT_IRQ(soft_irq), .EVT_IRQ(evt_irq));

  wb_core_model cpu_u (.clk(clk), .ack(ack), .cyc(cyc), .stb(stb),
    .we(we), .sel(sel), .adr(adr), .wdat(wdat));

  function automatic logic [31:0] rnd();
    lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
    return lfsr;
  endfunction

  task automatic check(input string n, input logic [31:0] e,
                       input logic [31:0] s);
    num_checks++;
    if (s !== e) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", n, e, s);
    end
  endtask

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    cpu_u.xfer(1'b1, a, d, 4'hf);
  endtask

  // A read notes its expectation first; the monitor compares it.
  task automatic rd(input logic [31:0] a, input logic [31:0] e,
                    input string n);
    exp_q.push_back(e);
    name_q.push_back(n);
    cpu_u.xfer(1'b0, a, 32'h0000_0000, 4'hf);
  endtask

  // Interrupt pins {evt, soft, tick}, looked at once they have settled.
  task automatic irqs(input logic [2:0] e);
    repeat (2) @(negedge clk);
    check("irq pins", {29'h0, e}, {29'h0, evt_irq, soft_irq, tick_irq});
  endtask

  // Runs the counter between two control writes; n is edges in between.
  task automatic run_for(input logic [31:0] ctl, input int gap,
                         output int n);
    int t;
    wr(ADDR_CTRL, ctl);
    t = cyc_n;
    repeat (gap) @(posedge clk);
    wr(ADDR_CTRL, ctl & ~32'h0000_0001);
    n = cyc_n - t;
  endtask

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  // Read data is taken at the edge where ack is sampled high.
  always @(posedge clk) begin
    if (ack === 1'b1 && we === 1'b0 && exp_q.size() != 0) begin
      check(name_q.pop_front(), exp_q.pop_front(), rdat);
    end
  end

  // A hang counts as a mismatch and ends the run the normal way.
  initial begin
    repeat (20000) @(posedge clk);
    bad_count++;
    tally_and_finish();
  end

  initial begin
    int n;
    logic [31:0] v, m;
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    rd(ADDR_CTRL, 32'h0, "ctrl reset");
    rd(ADDR_STAT, 32'h0, "status reset");
    rd(ADDR_CNT, 32'h0, "count reset");
    rd(ADDR_MATCH, 32'h0, "match reset");
    wr(32'he000_f00c, 32'hffff_ffff);
    rd(32'he000_f00c, 32'h0, "unused offset");
    v = rnd();
    m = rnd();
    wr(ADDR_CNT, v);
    wr(ADDR_MATCH, m);
    rd(ADDR_CNT, v, "count rw");
    rd(ADDR_MATCH, m, "match rw");
    cpu_u.xfer(1'b1, ADDR_MATCH, 32'haaaa_aaaa, 4'h2);
    rd(ADDR_MATCH, {m[31:16], 8'haa, m[7:0]}, "match lane 1");
    $display("test reset and access done");
    // Up count without reload runs straight through the match value.
    m = rnd();
    wr(ADDR_MATCH, m);
    wr(ADDR_CNT, m - 32'h3);
    run_for(32'h0000_0007, 9, n);
    rd(ADDR_CNT, m - 32'h3 + 32'(n), "up past match");
    rd(ADDR_CNT, m - 32'h3 + 32'(n), "held when stopped");
    rd(ADDR_STAT, 32'h1, "flag set");
    irqs(3'b001);
    wr(ADDR_STAT, 32'h1);
    rd(ADDR_STAT, 32'h1, "flag after write 1");
    wr(ADDR_CTRL, 32'h4);
    irqs(3'b000);
    wr(ADDR_STAT, 32'h0);
    rd(ADDR_STAT, 32'h0, "flag after write 0");
    wr(ADDR_CTRL, 32'h6);
    irqs(3'b000);
    $display("test match flag done");
    // Reload wraps every sixth tick; the event bank sees both events.
    wr(ADDR_MATCH, 32'h5);
    wr(ADDR_CNT, 32'h0);
    run_for(32'h0000_000f, 20, n);
    rd(ADDR_CNT, 32'(n % 6), "reload count");
    rd(ADDR_EVT_STAT, 32'h3, "events");
    irqs(3'b001);
    wr(ADDR_EVT_EN, 32'h2);
    irqs(3'b101);
    wr(ADDR_EVT_EN, 32'h0);
    irqs(3'b001);
    wr(ADDR_EVT_EN, 32'h3);
    wr(ADDR_EVT_CLR, 32'h3);
    rd(ADDR_EVT_STAT, 32'h0, "events cleared");
    irqs(3'b001);
    $display("test reload and events done");
    // Down count without reload wraps from zero to all ones.
    wr(ADDR_STAT, 32'h0);
    wr(ADDR_MODE, 32'h1);
    wr(ADDR_CNT, 32'h2);
    run_for(32'h0000_0005, 9, n);
    rd(ADDR_CNT, 32'h2 - 32'(n), "down wrap");
    rd(ADDR_STAT, 32'h0, "no flag when down");
    irqs(3'b100);
    wr(ADDR_MODE, 32'h0);
    // Slow time base ticks once per divider period.
    wr(ADDR_CNT, 32'h0);
    run_for(32'h0000_0001, 40, n);
    rd(ADDR_CNT, 32'(n / TICK_DIV), "slow ticks");
    rd(ADDR_STAT, 32'h1, "flag on slow match");
    $display("test down and slow done");
    // The soft request stands until software writes the bit back to 0.
    wr(ADDR_EVT_CLR, 32'h3);
    wr(ADDR_CTRL, 32'h8000_0000);
    irqs(3'b010);
    repeat (30) @(posedge clk);
    irqs(3'b010);
    wr(ADDR_CTRL, 32'h0);
    irqs(3'b000);
    $display("test soft interrupt done");
    tally_and_finish();
  end
endmodule
